// ### host_model.sv
/* Host end of the serial link: sends frames on rxd_o, decodes txd_i.
   Assumes the bench sets bt, nb, par and two to match the device. */
`timescale 1ns/10ps
module host_model
    import serial_port_pkg::*;
(
    // Clock
    input  wire logic clk_i,
    // From device
    input  wire logic txd_i,
    // To device
    output logic      rxd_o,
    output logic      cts_o
);
    int         bt  = 16;
    int         nb  = 8;
    logic [1:0] par = PAR_NONE;
    logic       two = 1'b0;
    logic [9:0] got[$];

    // Line idles at mark, clear to send true
    initial begin
        rxd_o = 1'b1;
        cts_o = 1'b1;
    end

    // One frame LSB first; bad flips parity to provoke an error
    task automatic send(input logic [7:0] d, input logic bad);
        rxd_o <= 1'b0;
        repeat (bt) @(posedge clk_i);
        for (int i = 0; i < nb; i++) begin
            rxd_o <= d[i];
            repeat (bt) @(posedge clk_i);
        end
        if (par != PAR_NONE) begin
            rxd_o <= ^(d & (nb == 8 ? 8'hFF : 8'h7F)) ^ (par == PAR_ODD) ^ bad;
            repeat (bt) @(posedge clk_i);
        end
        rxd_o <= 1'b1;
        repeat (two ? 2 * bt : bt) @(posedge clk_i);
    endtask

    // Decoder samples mid-bit on the falling edge, clear of register updates
    always begin : decode
        logic [9:0] r;
        @(negedge txd_i);
        repeat (bt / 2) @(negedge clk_i);
        r = 10'h000;
        for (int i = 0; i <= nb + (par != PAR_NONE); i++) begin
            repeat (bt) @(negedge clk_i);
            r[i] = txd_i;
        end
        got.push_back(r);
    end
endmodule

// ### instrument_serial_port.sv
/*
 * Serial port of a bench instrument: UART with selectable format, X-on/X-off
 * and RTS/CTS flow control, and a 256-byte receive buffer, behind a classic
 * Wishbone slave. Assumes rxd_i and cts_i are asynchronous line levels after
 * the transceiver (high = mark / true) and a 125 MHz clk_i.
 */
// What this block does
// - Bit rate selectable among 1200, 2400, 4800 and 9600 baud.
// - Frame is one start bit, 7 or 8 data bits, 1 or 2 stops.
// - Even, odd or no parity; inserted on transmit, checked on receive.
// - Configuration fixes RTS/CTS true or uses them for flow control.
// - Software flow control uses resume 11H and pause 13H.
// - Drives TXD and RTS, samples RXD and CTS from the host.
// - Only TXD, RXD, RTS and CTS are used; other modem lines ignored.
// - Software reads host requests and sends answers through the registers.
// - Mode 0 none, 1 software both, 2 software tx/hardware rx, 3 hardware.
// - Pause at 64 free bytes, resume at 192, by character or RTS.
// - Hardware tx control halts while CTS false; flow characters are data.
// - Without rx handshake RTS stays true and bytes into a full buffer drop.
`timescale 1ns/10ps
module instrument_serial_port
    import serial_port_pkg::*;
#(
    parameter int TICK_DIV_P = TICK_DIV
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Serial line; no other modem signals exist on this port
    input  wire logic        rxd_i,
    input  wire logic        cts_i,
    output logic             txd_o,
    output logic             rts_o
);
    localparam logic [12:0] DIV_LAST = 13'(TICK_DIV_P - 1);

    ctrl_s       ctrl, next_ctrl;
    logic        rxd_meta, rxd_sync, cts_meta, cts_sync;
    logic [12:0] div_cnt, next_div_cnt;
    logic [2:0]  pre_cnt, next_pre_cnt;
    logic        os_tick, next_os_tick;
    rx_state_e   rx_state, next_rx_state;
    logic [3:0]  rx_os, next_rx_os, rx_bit, next_rx_bit, rx_nb;
    logic [8:0]  rx_sh, next_rx_sh, rx_aligned;
    logic        rx_done, rx_stop_bad, rx_par_bad;
    logic [7:0]  rx_byte;
    tx_state_e   tx_state, next_tx_state;
    logic [11:0] tx_sh, next_tx_sh;
    logic [3:0]  tx_left, next_tx_left, tx_os, next_tx_os;
    logic        tx_pause, launch_flow, launch_data, need_flow, sw_tx;
    logic [7:0]  wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr, rd_data;
    logic [8:0]  rx_count, next_rx_count;
    logic        sw_paused, next_sw_paused, rx_held, next_rx_held;
    logic        sent_held, next_sent_held, next_rts;
    logic        par_err, next_par_err, frm_err, next_frm_err;
    logic        ovr_err, next_ovr_err;
    logic [7:0]  hold_data, next_hold_data;
    logic        hold_full, next_hold_full;
    logic        stage, next_stage, avail_snap, next_ack;
    logic [31:0] next_dat;
    logic        bus_go, wr_en, pop;

    // Data bits plus optional parity bit
    function automatic logic [3:0] frame_bits(input ctrl_s c);
        return 4'h7 + {3'h0, c.word8} + {3'h0, c.parity != PAR_NONE};
    endfunction

    // Builds the LSB-first frame; unused upper bits are stop level
    function automatic logic [11:0] tx_frame(input ctrl_s c, input logic [7:0] d);
        logic [11:0] f;
        logic        p;
        f = 12'hFFF;
        f[0] = 1'b0;
        p = ^(c.word8 ? d : {1'b0, d[6:0]}) ^ (c.parity == PAR_ODD);
        if (c.word8) begin
            f[8:1] = d;
            if (c.parity != PAR_NONE) f[9] = p;
        end else begin
            f[7:1] = d[6:0];
            if (c.parity != PAR_NONE) f[8] = p;
        end
        return f;
    endfunction

    // Line inputs are asynchronous, so each passes two flops first
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rxd_meta <= 1'b1;
            rxd_sync <= 1'b1;
            cts_meta <= 1'b0;
            cts_sync <= 1'b0;
        end else begin
            rxd_meta <= rxd_i;
            rxd_sync <= rxd_meta;
            cts_meta <= cts_i;
            cts_sync <= cts_meta;
        end
    end

    // 16x tick: base divider for 9600, then prescale for slower rates
    always_comb begin
        next_os_tick = 1'b0;
        next_div_cnt = div_cnt + 13'h1;
        next_pre_cnt = pre_cnt;
        if (div_cnt >= DIV_LAST) begin
            next_div_cnt = 13'h0;
            if (pre_cnt >= (3'h7 >> ctrl.baud)) begin
                next_pre_cnt = 3'h0;
                next_os_tick = 1'b1;
            end else begin
                next_pre_cnt = pre_cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt <= 13'h0;
            pre_cnt <= 3'h0;
            os_tick <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            pre_cnt <= next_pre_cnt;
            os_tick <= next_os_tick;
        end
    end

    // Receiver: start validated at mid-bit, then one sample per bit
    assign rx_nb      = frame_bits(ctrl);
    assign rx_aligned = rx_sh >> (4'h9 - rx_nb);
    assign rx_byte    = ctrl.word8 ? rx_aligned[7:0] : {1'b0, rx_aligned[6:0]};
    assign rx_par_bad = (ctrl.parity != PAR_NONE) &&
                        ((^rx_aligned) != (ctrl.parity == PAR_ODD));

    always_comb begin
        next_rx_state = rx_state;
        next_rx_os    = rx_os;
        next_rx_bit   = rx_bit;
        next_rx_sh    = rx_sh;
        rx_done       = 1'b0;
        rx_stop_bad   = 1'b0;
        if (os_tick) begin
            next_rx_os = rx_os + 4'h1;
            case (rx_state)
                RX_IDLE: begin
                    next_rx_os = 4'h0;
                    if (!rxd_sync) next_rx_state = RX_START;
                end
                RX_START: begin
                    if (rx_os == 4'h7) begin
                        next_rx_os    = 4'h0;
                        next_rx_bit   = 4'h0;
                        next_rx_state = rxd_sync ? RX_IDLE : RX_DATA; // Glitch filter
                    end
                end
                RX_DATA: begin
                    if (rx_os == 4'hF) begin
                        next_rx_sh  = {rxd_sync, rx_sh[8:1]};
                        next_rx_bit = rx_bit + 4'h1;
                        if (rx_bit == rx_nb - 4'h1) next_rx_state = RX_STOP;
                    end
                end
                RX_STOP: begin
                    // Only the first stop bit is checked; a second is idle time
                    if (rx_os == 4'hF) begin
                        rx_done       = 1'b1;
                        rx_stop_bad   = !rxd_sync;
                        next_rx_state = RX_IDLE;
                    end
                end
                default: next_rx_state = RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_state <= RX_IDLE;
            rx_os    <= 4'h0;
            rx_bit   <= 4'h0;
            rx_sh    <= 9'h0;
        end else begin
            rx_state <= next_rx_state;
            rx_os    <= next_rx_os;
            rx_bit   <= next_rx_bit;
            rx_sh    <= next_rx_sh;
        end
    end

    // Transmitter: flow characters go first and ignore a received pause
    assign sw_tx = (ctrl.flow == SOFTWARE_BOTH_WAYS_MODE) ||
                   (ctrl.flow == SOFT_TX_HARD_RX_MODE);
    assign tx_pause = sw_tx ? sw_paused :
                      ((ctrl.flow == MODE_HARD_BOTH) && !cts_sync);
    assign need_flow   = (ctrl.flow == SOFTWARE_BOTH_WAYS_MODE) && (rx_held != sent_held);
    assign launch_flow = (tx_state == TX_IDLE) && need_flow;
    assign launch_data = (tx_state == TX_IDLE) && !need_flow && hold_full && !tx_pause;

    always_comb begin
        next_tx_state = tx_state;
        next_tx_sh    = tx_sh;
        next_tx_left  = tx_left;
        next_tx_os    = tx_os;
        case (tx_state)
            TX_IDLE: begin
                if (launch_flow || launch_data) begin
                    next_tx_sh = tx_frame(ctrl, launch_flow ?
                        (rx_held ? CHAR_PAUSE : CHAR_RESUME) : hold_data);
                    next_tx_left  = 4'h1 + frame_bits(ctrl) + (ctrl.two_stop ? 4'h2 : 4'h1);
                    next_tx_os    = 4'h0;
                    next_tx_state = TX_SEND;
                end
            end
            TX_SEND: begin
                if (os_tick) begin
                    next_tx_os = tx_os + 4'h1;
                    if (tx_os == 4'hF) begin
                        next_tx_sh   = {1'b1, tx_sh[11:1]};
                        next_tx_left = tx_left - 4'h1;
                        if (tx_left == 4'h1) next_tx_state = TX_IDLE;
                    end
                end
            end
            default: next_tx_state = TX_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_state <= TX_IDLE;
            tx_sh    <= 12'hFFF;
            tx_left  <= 4'h0;
            tx_os    <= 4'h0;
        end else begin
            tx_state <= next_tx_state;
            tx_sh    <= next_tx_sh;
            tx_left  <= next_tx_left;
            tx_os    <= next_tx_os;
        end
    end

    assign txd_o = tx_sh[0];

    // Buffer, flow state and bus: answers two edges after the request
    assign bus_go = wb_cyc_i && wb_stb_i && stage;
    assign pop    = bus_go && !wb_we_i && (wb_adr_i == ADDR_RXDATA) && avail_snap;

    always_comb begin
        next_ctrl      = ctrl;
        next_stage     = wb_cyc_i && wb_stb_i && !wb_ack_o && !stage;
        next_ack       = bus_go;
        next_dat       = wb_dat_o;
        next_hold_data = hold_data;
        next_hold_full = hold_full && !launch_data;
        next_sw_paused = sw_tx ? sw_paused : 1'b0;
        next_par_err   = par_err;
        next_frm_err   = frm_err;
        next_ovr_err   = ovr_err;
        wr_en          = 1'b0;
        if (bus_go) begin
            next_dat = 32'h0;
            if (wb_we_i) begin
                if (wb_adr_i == ADDR_CTRL && wb_sel_i[0]) begin
                    next_ctrl = ctrl_s'(wb_dat_i[7:0]);
                end else if (wb_adr_i == ADDR_STATUS && wb_sel_i[1]) begin
                    next_par_err = par_err && !wb_dat_i[ST_PAR_BIT];
                    next_frm_err = frm_err && !wb_dat_i[ST_FRM_BIT];
                    next_ovr_err = ovr_err && !wb_dat_i[ST_OVR_BIT];
                end else if (wb_adr_i == ADDR_TXDATA && wb_sel_i[0] && !hold_full) begin
                    next_hold_data = wb_dat_i[7:0];
                    next_hold_full = 1'b1;
                end
            end else if (wb_adr_i == ADDR_CTRL) begin
                next_dat = {24'h0, ctrl};
            end else if (wb_adr_i == ADDR_STATUS) begin
                next_dat = {16'h0, ovr_err, frm_err, par_err, rts_o, tx_pause,
                            hold_full, tx_state == TX_SEND, rx_count};
            end else if (wb_adr_i == ADDR_RXDATA) begin
                next_dat = {23'h0, avail_snap, avail_snap ? rd_data : 8'h00};
            end
        end
        // Hardware set wins over a same-cycle software clear
        if (rx_done) begin
            if (rx_par_bad) next_par_err = 1'b1;
            if (rx_stop_bad) next_frm_err = 1'b1;
            if (sw_tx && rx_byte == CHAR_PAUSE) begin
                next_sw_paused = 1'b1;
            end else if (sw_tx && rx_byte == CHAR_RESUME) begin
                next_sw_paused = 1'b0;
            end else if (rx_count == FULL_COUNT) begin
                next_ovr_err = 1'b1;
            end else begin
                wr_en = 1'b1;
            end
        end
        next_wr_ptr   = wr_ptr + {7'h0, wr_en};
        next_rd_ptr   = rd_ptr + {7'h0, pop};
        next_rx_count = rx_count + {8'h0, wr_en} - {8'h0, pop};
        // Hysteresis between the pause and resume fill levels
        next_rx_held = rx_held;
        // Follows the mode being written so RTS never lags a mode change
        if (next_ctrl.flow == MODE_OFF) begin
            next_rx_held = 1'b0;
        end else if (next_rx_count >= HOLD_COUNT) begin
            next_rx_held = 1'b1;
        end else if (next_rx_count <= RELEASE_COUNT) begin
            next_rx_held = 1'b0;
        end
        next_rts = !(next_rx_held && next_ctrl.flow[1]);
        if (ctrl.flow != SOFTWARE_BOTH_WAYS_MODE) begin
            next_sent_held = 1'b0;
        end else begin
            next_sent_held = launch_flow ? rx_held : sent_held;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl       <= ctrl_s'(CTRL_RESET);
            stage      <= 1'b0;
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= 32'h0;
            avail_snap <= 1'b0;
            hold_data  <= 8'h00;
            hold_full  <= 1'b0;
            wr_ptr     <= 8'h00;
            rd_ptr     <= 8'h00;
            rx_count   <= 9'h000;
            sw_paused  <= 1'b0;
            rx_held    <= 1'b0;
            sent_held  <= 1'b0;
            rts_o      <= 1'b1;
            par_err    <= 1'b0;
            frm_err    <= 1'b0;
            ovr_err    <= 1'b0;
        end else begin
            ctrl       <= next_ctrl;
            stage      <= next_stage;
            wb_ack_o   <= next_ack;
            wb_dat_o   <= next_dat;
            avail_snap <= (rx_count != 9'h000); // Matches the registered read
            hold_data  <= next_hold_data;
            hold_full  <= next_hold_full;
            wr_ptr     <= next_wr_ptr;
            rd_ptr     <= next_rd_ptr;
            rx_count   <= next_rx_count;
            sw_paused  <= next_sw_paused;
            rx_held    <= next_rx_held;
            sent_held  <= next_sent_held;
            rts_o      <= next_rts;
            par_err    <= next_par_err;
            frm_err    <= next_frm_err;
            ovr_err    <= next_ovr_err;
        end
    end

    rx_buffer_mem #(.WIDTH(8), .DEPTH(BUF_DEPTH), .AW(8)) u_rx_buffer (
        .clk_i     (clk_i),
        .wr_en_i   (wr_en),
        .wr_addr_i (wr_ptr),
        .wr_data_i (rx_byte),
        .rd_addr_i (rd_ptr),
        .rd_data_o (rd_data)
    );

    // Checks on the behaviour above
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_TX_START:
    assert property ((launch_flow || launch_data) |=> !txd_o ##1 !txd_o)
        else $error("start bit not driven after launch");
    AST_TXD_IDLE:
    assert property ((tx_state == TX_IDLE) && $past(tx_state == TX_IDLE) |-> txd_o)
        else $error("txd not at mark while idle");
    AST_RTS_FIXED:
    assert property (!next_ctrl.flow[1] |=> rts_o)
        else $error("rts dropped without receive handshake");
    AST_RTS_DROP:
    assert property (next_ctrl.flow[1] && next_rx_count >= HOLD_COUNT |=> !rts_o)
        else $error("rts still true at pause level");
    AST_CTS_HALT:
    assert property ((ctrl.flow == MODE_HARD_BOTH) && !cts_sync && tx_state == TX_IDLE
                     |-> !launch_data && !launch_flow)
        else $error("transmission started while cts false");
    AST_FULL_DROP:
    assert property (rx_done && rx_count == FULL_COUNT && !pop &&
                     !(sw_tx && (rx_byte == CHAR_PAUSE || rx_byte == CHAR_RESUME))
                     |=> rx_count == FULL_COUNT && ovr_err)
        else $error("full buffer accepted a byte");
    AST_XOFF_PAUSE:
    assert property (rx_done && sw_tx && rx_byte == CHAR_PAUSE && next_ctrl == ctrl
                     |=> tx_pause && rx_count == $past(rx_count) - {8'h0, $past(pop)})
        else $error("pause character not honoured");
    AST_PARITY_FLAG:
    assert property (rx_done && rx_par_bad |=> par_err)
        else $error("parity error not flagged");
    AST_BUS_ACK:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !stage |=> !wb_ack_o ##1 wb_ack_o)
        else $error("bus answer not two edges after request");
endmodule

// ### rx_buffer_mem.sv
/*
 * Simple dual-port byte memory for the receive buffer with a registered
 * read port. Assumes one clock; read data lag the address by one edge.
 */
`timescale 1ns/10ps
module rx_buffer_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    // Clock
    input  wire logic             clk_i,
    // Write port
    input  wire logic             wr_en_i,
    input  wire logic [AW-1:0]    wr_addr_i,
    input  wire logic [WIDTH-1:0] wr_data_i,
    // Read port
    input  wire logic [AW-1:0]    rd_addr_i,
    output logic      [WIDTH-1:0] rd_data_o
);
    logic [WIDTH-1:0] mem [DEPTH];

    // Storage is not reset; only pointers carry control state
    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule

// ### serial_port_pkg.sv
/*
 * Shared constants, configuration layout and state encodings of the
 * instrument serial port. Assumes a single 125 MHz system clock.
 */
package serial_port_pkg;
    // Bit timing: 16x oversampling derived from the fastest rate
    localparam int CLK_HZ     = 125_000_000;
    localparam int BASE_BAUD  = 9600;
    localparam int OVERSAMPLE = 16;
    localparam int TICK_DIV   = CLK_HZ / (BASE_BAUD * OVERSAMPLE);

    // Rate select codes (prescale of the 9600 tick by 8, 4, 2, 1)
    localparam logic [1:0] BAUD_1200 = 2'h0;
    localparam logic [1:0] BAUD_2400 = 2'h1;
    localparam logic [1:0] BAUD_4800 = 2'h2;
    localparam logic [1:0] BAUD_9600 = 2'h3;

    // Parity codes
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h1;
    localparam logic [1:0] PAR_ODD  = 2'h2;

    // Flow control modes
    localparam logic [1:0] MODE_OFF                = 2'h0;
    localparam logic [1:0] SOFTWARE_BOTH_WAYS_MODE = 2'h1;
    localparam logic [1:0] SOFT_TX_HARD_RX_MODE    = 2'h2;
    localparam logic [1:0] MODE_HARD_BOTH          = 2'h3;

    // Flow characters
    localparam logic [7:0] CHAR_RESUME = 8'h11;
    localparam logic [7:0] CHAR_PAUSE  = 8'h13;

    // Receive buffer and its thresholds in free bytes
    localparam int BUF_DEPTH   = 256;
    localparam int PAUSE_FREE  = 64;
    localparam int RESUME_FREE = 192;
    localparam logic [8:0] FULL_COUNT    = 9'(BUF_DEPTH);
    localparam logic [8:0] HOLD_COUNT    = 9'(BUF_DEPTH - PAUSE_FREE);
    localparam logic [8:0] RELEASE_COUNT = 9'(BUF_DEPTH - RESUME_FREE);

    // Register byte offsets
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_TXDATA = 4'h8;
    localparam logic [3:0] ADDR_RXDATA = 4'hC;

    // Reset value: 9600 baud, 8 data bits, no parity, 1 stop, no handshake
    localparam logic [7:0] CTRL_RESET = 8'h07;

    // Write-one-to-clear error bits of the status word
    localparam int ST_PAR_BIT = 13;
    localparam int ST_FRM_BIT = 14;
    localparam int ST_OVR_BIT = 15;

    typedef struct packed {
        logic [1:0] flow;
        logic       two_stop;
        logic [1:0] parity;
        logic       word8;
        logic [1:0] baud;
    } ctrl_s;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'h1,
        RX_START = 4'h2,
        RX_DATA  = 4'h4,
        RX_STOP  = 4'h8
    } rx_state_e;

    typedef enum logic [1:0] {
        TX_IDLE = 2'h1,
        TX_SEND = 2'h2
    } tx_state_e;
endpackage

// ### tb.sv
/* Self-checking bench of the serial port: random frames at every rate and parity,
   flow control by character and by RTS/CTS. Assumes TICK_DIV_P of 1. */
`timescale 1ns/10ps
module tb;
    import serial_port_pkg::*;
    logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
    logic        rxd_i, cts_i, txd_o, rts_o;
    logic [3:0]  wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [7:0]  d, c, q[$];
    int          mismatches, checked;

    instrument_serial_port #(.TICK_DIV_P(1)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .rxd_i(rxd_i), .cts_i(cts_i), .txd_o(txd_o), .rts_o(rts_o));
    host_model u_host (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i), .cts_o(cts_i));

    // 125 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task test_done;
        if (mismatches == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("Error at %0t ns: got %h expected %h", $time, g, e);
        end
    endtask

    // Classic cycle; holds the request until ack is sampled, then one idle cycle
    task wb(input logic [3:0] a, input logic we, input logic [31:0] dat);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= dat;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Expected decoded frame: data, optional parity, stop
    function automatic logic [9:0] frm(input logic [7:0] v, input int nb, input logic [1:0] p);
        logic [9:0] r;
        r = 10'h000;
        for (int j = 0; j < nb; j++) r[j] = v[j];
        if (p != PAR_NONE) r[nb] = ^(v & (nb == 8 ? 8'hFF : 8'h7F)) ^ (p == PAR_ODD);
        r[nb + (p != PAR_NONE)] = 1'b1;
        return r;
    endfunction

    task cfg(input logic [7:0] v);
        wb(ADDR_CTRL, 1'b1, {24'h0, v});
        u_host.bt  = 16 * (8 >> v[1:0]);
        u_host.nb  = v[2] ? 8 : 7;
        u_host.par = v[4:3];
        u_host.two = v[5];
    endtask

    // Bounded wait, since a missing frame must not hang the run
    task expect_tx(input logic [9:0] e);
        int n;
        n = 0;
        while (u_host.got.size() == 0 && n < 5000) begin
            @(posedge clk_i);
            n++;
        end
        chk(u_host.got.size() > 0 ? u_host.got.pop_front() : 'x, e);
    endtask

    initial begin
        repeat (90000) @(posedge clk_i);
        mismatches++;
        test_done;
    end

    initial begin
        {rst_i, wb_sel_i} = 5'h1F;
        {wb_we_i, wb_cyc_i, wb_stb_i, wb_adr_i, wb_dat_i} = '0;
        mismatches = 0;
        checked = 0;
        void'($urandom(32'hDE85));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(txd_o, 1);
        chk(rts_o, 1);
        wb(ADDR_CTRL, 1'b0, 0);
        chk(rd, CTRL_RESET);
        wb(4'h2, 1'b0, 0);
        chk(rd, 0);
        // Every rate and parity code, random word length and stops
        for (int k = 0; k < 12; k++) begin
            c = {2'h0, 1'($urandom), 2'(k % 3), 1'($urandom), 2'(k % 4)};
            cfg(c);
            d = 8'($urandom);
            wb(ADDR_TXDATA, 1'b1, {24'h0, d});
            expect_tx(frm(d, u_host.nb, c[4:3]));
            d = 8'($urandom);
            u_host.send(d, 1'b0);
            wb(ADDR_RXDATA, 1'b0, 0);
            chk(rd, {23'h0, 1'b1, d & (c[2] ? 8'hFF : 8'h7F)});
        end
        cfg(8'h0F);
        u_host.send(8'hA5, 1'b1);
        wb(ADDR_STATUS, 1'b0, 0);
        chk(rd[ST_PAR_BIT], 1);
        // Error bits clear on a one written; the byte itself is still kept
        wb(ADDR_STATUS, 1'b1, 32'h2000);
        wb(ADDR_STATUS, 1'b0, 0);
        chk(rd[15:13], 0);
        wb(ADDR_RXDATA, 1'b0, 0);
        chk(rd, {23'h0, 1'b1, 8'hA5});
        // Fill to 64 free bytes under RTS receive control
        cfg(8'h87);
        repeat (192) begin
            d = 8'($urandom) | 8'h80;
            q.push_back(d);
            if (q.size() == 192) chk(rts_o, 1);
            u_host.send(d, 1'b0);
        end
        repeat (2) @(posedge clk_i);
        chk(rts_o, 0);
        cfg(8'h47);
        expect_tx(frm(CHAR_PAUSE, 8, PAR_NONE));
        repeat (192) begin
            wb(ADDR_RXDATA, 1'b0, 0);
            chk(rd, {23'h0, 1'b1, q.pop_front()});
            if (q.size() == 129) chk(u_host.got.size(), 0);
        end
        expect_tx(frm(CHAR_RESUME, 8, PAR_NONE));
        // Host pauses and resumes the device by character
        u_host.send(CHAR_PAUSE, 1'b0);
        wb(ADDR_TXDATA, 1'b1, 32'h5A);
        repeat (480) @(posedge clk_i);
        chk(u_host.got.size(), 0);
        u_host.send(CHAR_RESUME, 1'b0);
        expect_tx(frm(8'h5A, 8, PAR_NONE));
        wb(ADDR_RXDATA, 1'b0, 0);
        chk(rd, 0);
        // Hardware transmit control; flow characters pass as data
        cfg(8'hC7);
        u_host.cts_o <= 1'b0;
        @(posedge clk_i);
        wb(ADDR_TXDATA, 1'b1, {24'h0, CHAR_PAUSE});
        repeat (480) @(posedge clk_i);
        chk(u_host.got.size(), 0);
        u_host.cts_o <= 1'b1;
        expect_tx(frm(CHAR_PAUSE, 8, PAR_NONE));
        u_host.send(CHAR_RESUME, 1'b0);
        wb(ADDR_RXDATA, 1'b0, 0);
        chk(rd, {23'h0, 1'b1, CHAR_RESUME});
        chk(rts_o, 1);
        test_done;
    end
endmodule
